/* File: shared/dma_status_pkg.sv */
// shared constants for the stream-to-memory status block
package dma_status_pkg;

  // bus geometry
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned STRB_W = DATA_W / 8;

  // register byte offsets
  localparam logic [ADDR_W-1:0] CTRL_OFS = 4'h0;
  localparam logic [ADDR_W-1:0] STAT_OFS = 4'h4;

  // control word fields (enables share the status flag positions)
  localparam int unsigned RUN_BIT = 0;
  // status word fields
  localparam int unsigned STOP_BIT = 0;
  localparam int unsigned INT_FAULT_BIT = 8;
  localparam int unsigned SLV_FAULT_BIT = 9;
  localparam int unsigned DEC_FAULT_BIT = 10;
  localparam int unsigned RSV_LO_BIT = 11;
  localparam int unsigned CMP_IRQ_BIT = 12;
  localparam int unsigned DLY_IRQ_BIT = 13;
  localparam int unsigned ERR_IRQ_BIT = 14;
  localparam int unsigned RSV_HI_BIT = 15;
  localparam int unsigned THR_LSB = 16;
  localparam int unsigned WAIT_LSB = 24;
  localparam int unsigned FIELD_W = 8;
  localparam int unsigned NUM_IRQ = 3;

  // byte lanes carrying each group
  localparam int unsigned LANE_RUN = 0;
  localparam int unsigned LANE_FLAGS = 1;
  localparam int unsigned LANE_THR = 2;
  localparam int unsigned LANE_WAIT = 3;

  // reset values
  localparam logic [7:0] THR_RST = 8'h01;
  localparam logic [7:0] WAIT_RST = 8'h00;

  // response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // halt sequencer states
  typedef enum logic [1:0] {
    HS_STOPPED = 2'b00,
    HS_RUNNING = 2'b01,
    HS_DRAINING = 2'b10
  } halt_state_e;

endpackage : dma_status_pkg

/* File: design/axil_port.sv */
// axi4-lite slave handshake front end for the status block
`timescale 1ns/1ps
`default_nettype none
module axil_port (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // write address and data channels
  input wire logic [dma_status_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [dma_status_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [dma_status_pkg::STRB_W-1:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // write response channel
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // read channels
  input wire logic [dma_status_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [dma_status_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // register file side
  output logic wr_fire,
  output logic [dma_status_pkg::ADDR_W-1:0] wr_addr,
  output logic [dma_status_pkg::DATA_W-1:0] wr_data,
  output logic [dma_status_pkg::STRB_W-1:0] wr_strb,
  input wire logic wr_ok,
  output logic rd_fire,
  output logic [dma_status_pkg::ADDR_W-1:0] rd_addr,
  input wire logic [dma_status_pkg::DATA_W-1:0] rd_data,
  input wire logic rd_ok
);
  import dma_status_pkg::*;

  logic aw_full_q, aw_full_d, w_full_q, w_full_d, b_q, b_d;
  logic ar_full_q, ar_full_d, r_q, r_d;
  logic [ADDR_W-1:0] awa_q, awa_d, ara_q, ara_d;
  logic [DATA_W-1:0] wd_q, wd_d, rd_q, rd_d;
  logic [STRB_W-1:0] ws_q, ws_d;
  logic [1:0] br_q, br_d, rr_q, rr_d;

  // ready while nothing is held and no answer waits
  assign s_axi_awready = !aw_full_q && !b_q;
  assign s_axi_wready = !w_full_q && !b_q;
  assign s_axi_arready = !ar_full_q && !r_q;
  assign wr_fire = aw_full_q && w_full_q;
  assign rd_fire = ar_full_q;
  assign wr_addr = awa_q;
  assign wr_data = wd_q;
  assign wr_strb = ws_q;
  assign rd_addr = ara_q;
  assign s_axi_bvalid = b_q;
  assign s_axi_bresp = br_q;
  assign s_axi_rvalid = r_q;
  assign s_axi_rresp = rr_q;
  assign s_axi_rdata = rd_q;

  // next state of both channel pairs
  always_comb begin
    aw_full_d = aw_full_q;
    w_full_d = w_full_q;
    b_d = b_q;
    br_d = br_q;
    awa_d = awa_q;
    wd_d = wd_q;
    ws_d = ws_q;
    ar_full_d = ar_full_q;
    r_d = r_q;
    rr_d = rr_q;
    ara_d = ara_q;
    rd_d = rd_q;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_full_d = 1'b1;
      awa_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_full_d = 1'b1;
      wd_d = s_axi_wdata;
      ws_d = s_axi_wstrb;
    end
    if (wr_fire) begin
      aw_full_d = 1'b0;
      w_full_d = 1'b0;
      b_d = 1'b1;
      br_d = wr_ok ? RESP_OKAY : RESP_DECERR;
    end else if (b_q && s_axi_bready) begin
      b_d = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      ar_full_d = 1'b1;
      ara_d = s_axi_araddr;
    end
    if (rd_fire) begin
      ar_full_d = 1'b0;
      r_d = 1'b1;
      rd_d = rd_ok ? rd_data : '0;
      rr_d = rd_ok ? RESP_OKAY : RESP_DECERR;
    end else if (r_q && s_axi_rready) begin
      r_d = 1'b0;
    end
  end

  // channel state registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      b_q <= 1'b0;
      br_q <= RESP_OKAY;
      awa_q <= '0;
      wd_q <= '0;
      ws_q <= '0;
      ar_full_q <= 1'b0;
      r_q <= 1'b0;
      rr_q <= RESP_OKAY;
      ara_q <= '0;
      rd_q <= '0;
    end else begin
      aw_full_q <= aw_full_d;
      w_full_q <= w_full_d;
      b_q <= b_d;
      br_q <= br_d;
      awa_q <= awa_d;
      wd_q <= wd_d;
      ws_q <= ws_d;
      ar_full_q <= ar_full_d;
      r_q <= r_d;
      rr_q <= rr_d;
      ara_q <= ara_d;
      rd_q <= rd_d;
    end
  end

endmodule : axil_port
`default_nettype wire

/* File: design/halt_sequencer.sv */
// graceful halt sequencing: stopped only after the engine drains
`timescale 1ns/1ps
`default_nettype none
module halt_sequencer (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // control and engine state
  input wire logic run_stop,
  input wire logic engine_idle,
  // status
  output logic stopped_indication
);
  import dma_status_pkg::*;

  halt_state_e state_q, state_d;

  // next state: stop request drains before reporting stopped
  always_comb begin
    case (state_q)
      HS_STOPPED: state_d = run_stop ? HS_RUNNING : HS_STOPPED;
      HS_RUNNING: state_d = run_stop ? HS_RUNNING : HS_DRAINING;
      HS_DRAINING: state_d = engine_idle ? HS_STOPPED : HS_DRAINING;
      default: state_d = HS_STOPPED;
    endcase
  end

  // state register, stopped out of reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= HS_STOPPED;
    end else begin
      state_q <= state_d;
    end
  end

  assign stopped_indication = (state_q == HS_STOPPED);

endmodule : halt_sequencer
`default_nettype wire

/* File: design/s2mm_dma_status_upper.sv */
// stream-to-memory status register, upper half, with control and irq
// Notes on behaviour
// [R1] completed descriptor fetched: internal fault, tail
// [R2] descriptor fault: clear run, then stopped
// [R3] slave error response sets slave fault
// [R4] decode error on pointer sets decode fault
// [R5] faults reported only in status register
// [R6] simple mode: three faults read zero
// [R7] bits 11 and 15 read zero
// [R8] end-of-frame or transfer done sets completion
// [R9] completion irq needs enable and threshold; simple mode skips the threshold
// [R10] delay timeout sets delay flag, zero simple
// [R11] any error sets error flag, irq
// [R12] bits 23:16 show threshold, reset 01h
// [R13] bits 31:24 show delay, reset 00h
// [R14] write one clears irq flag
// [R15] flags read zero after reset
`timescale 1ns/1ps
`default_nettype none
module s2mm_dma_status_upper #(
  parameter bit DESC_ENGINE_PRESENT = 1'b1
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write channels
  input wire logic [dma_status_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [dma_status_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [dma_status_pkg::STRB_W-1:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read channels
  input wire logic [dma_status_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [dma_status_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // descriptor engine events
  input wire logic desc_fetch_done,
  input wire logic desc_fetch_cmplt_set,
  input wire logic desc_resp_valid,
  input wire logic desc_resp_slverr,
  input wire logic desc_resp_decerr,
  // transfer and timer events
  input wire logic eof_desc_done,
  input wire logic xfer_done,
  input wire logic delay_timeout,
  input wire logic datapath_error,
  input wire logic threshold_reached,
  input wire logic engine_idle,
  // engine control and status
  output logic run_stop_control,
  output logic stopped_indication,
  output logic treat_as_tail,
  output logic [7:0] irq_count_limit_cfg,
  output logic [7:0] irq_wait_time_cfg,
  // interrupt
  output logic irq
);
  import dma_status_pkg::*;

  logic wr_fire, rd_fire, wr_ok, rd_ok;
  logic [ADDR_W-1:0] wr_addr, rd_addr;
  logic [DATA_W-1:0] wr_data, rd_data, status_word, ctrl_word;
  logic [STRB_W-1:0] wr_strb;
  logic ctrl_wr, stat_wr;
  logic int_ev, slv_ev, dec_ev, desc_err, cmp_ev, dly_ev, err_ev;
  logic run_q, run_d, irq_q, irq_d;
  logic [NUM_IRQ-1:0] en_q, en_d, flag_q, flag_d, ev_vec, clr_vec;
  logic [2:0] fault_q, fault_d;
  logic [7:0] thr_q, thr_d, wait_q, wait_d;

  // bus front end
  axil_port u_port (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .wr_fire(wr_fire),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_ok(wr_ok),
    .rd_fire(rd_fire),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_ok(rd_ok)
  );

  // address decode, word aligned
  assign ctrl_wr = wr_fire && (wr_addr[ADDR_W-1:2] == CTRL_OFS[ADDR_W-1:2]);
  assign stat_wr = wr_fire && (wr_addr[ADDR_W-1:2] == STAT_OFS[ADDR_W-1:2]);
  assign wr_ok = (wr_addr[ADDR_W-1:2] == CTRL_OFS[ADDR_W-1:2]) ||
                 (wr_addr[ADDR_W-1:2] == STAT_OFS[ADDR_W-1:2]);
  assign rd_ok = (rd_addr[ADDR_W-1:2] == CTRL_OFS[ADDR_W-1:2]) ||
                 (rd_addr[ADDR_W-1:2] == STAT_OFS[ADDR_W-1:2]);

  // event decode; simple mode masks engine-only sources
  // [R1] completed descriptor fetch
  assign int_ev = DESC_ENGINE_PRESENT && desc_fetch_done &&
                  desc_fetch_cmplt_set;
  // [R3] slave error on descriptor access
  assign slv_ev = DESC_ENGINE_PRESENT && desc_resp_valid && desc_resp_slverr;
  // [R4] decode error on descriptor pointer
  assign dec_ev = DESC_ENGINE_PRESENT && desc_resp_valid && desc_resp_decerr;
  assign desc_err = int_ev || slv_ev || dec_ev;
  // [R8] completion source per mode
  assign cmp_ev = DESC_ENGINE_PRESENT ? eof_desc_done : xfer_done;
  // [R10] delay timeout only with the engine
  assign dly_ev = DESC_ENGINE_PRESENT && delay_timeout;
  // [R11] every error reaches the error flag
  assign err_ev = desc_err || datapath_error;
  assign ev_vec = {err_ev, dly_ev, cmp_ev};
  // [R1] completed descriptor fetch (internal fault) ends the chain; slave and decode faults do not
  assign treat_as_tail = int_ev;

  // [R14] write-one-to-clear on the flag byte lane
  assign clr_vec = (stat_wr && wr_strb[LANE_FLAGS]) ?
                   wr_data[ERR_IRQ_BIT:CMP_IRQ_BIT] : '0;

  // control and status next values
  always_comb begin
    run_d = run_q;
    en_d = en_q;
    thr_d = thr_q;
    wait_d = wait_q;
    if (ctrl_wr && wr_strb[LANE_RUN]) begin
      run_d = wr_data[RUN_BIT];
    end
    if (ctrl_wr && wr_strb[LANE_FLAGS]) begin
      en_d = wr_data[ERR_IRQ_BIT:CMP_IRQ_BIT];
    end
    if (ctrl_wr && wr_strb[LANE_THR]) begin
      thr_d = wr_data[THR_LSB +: FIELD_W];
    end
    if (ctrl_wr && wr_strb[LANE_WAIT]) begin
      wait_d = wr_data[WAIT_LSB +: FIELD_W];
    end
    // [R2] fault drops run ahead of any write
    if (desc_err) begin
      run_d = 1'b0;
    end
    // [R5] faults stick here only, nothing goes to descriptors
    fault_d = fault_q | {dec_ev, slv_ev, int_ev};
    // [R14] a new event wins over a clear in the same cycle
    flag_d = (flag_q & ~clr_vec) | ev_vec;
    // [R9] completion gated by enable, and by threshold with the engine
    irq_d = (flag_q[0] && en_q[0] && (threshold_reached ||
             !DESC_ENGINE_PRESENT)) ||
            // [R10] delay flag through its enable
            (flag_q[1] && en_q[1]) ||
            // [R11] error flag through its enable
            (flag_q[2] && en_q[2]);
  end

  // control and status registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      run_q <= 1'b0;
      en_q <= '0;
      // [R12] threshold out of reset
      thr_q <= THR_RST;
      // [R13] delay out of reset
      wait_q <= WAIT_RST;
      // [R15] flags clear at reset
      fault_q <= '0;
      flag_q <= '0;
      irq_q <= 1'b0;
    end else begin
      run_q <= run_d;
      en_q <= en_d;
      thr_q <= thr_d;
      wait_q <= wait_d;
      fault_q <= fault_d;
      flag_q <= flag_d;
      irq_q <= irq_d;
    end
  end

  // [R2] stopped reported only once drained
  halt_sequencer u_halt (
    .aclk(aclk),
    .aresetn(aresetn),
    .run_stop(run_q),
    .engine_idle(engine_idle),
    .stopped_indication(stopped_indication)
  );

  // read words
  always_comb begin
    ctrl_word = '0;
    ctrl_word[RUN_BIT] = run_q;
    ctrl_word[ERR_IRQ_BIT:CMP_IRQ_BIT] = en_q;
    ctrl_word[THR_LSB +: FIELD_W] = thr_q;
    ctrl_word[WAIT_LSB +: FIELD_W] = wait_q;
    // [R7] reserved bits stay zero from the default
    status_word = '0;
    status_word[STOP_BIT] = stopped_indication;
    // [R6] faults masked in simple mode
    status_word[DEC_FAULT_BIT:INT_FAULT_BIT] =
      DESC_ENGINE_PRESENT ? fault_q : 3'h0;
    status_word[ERR_IRQ_BIT:CMP_IRQ_BIT] = flag_q;
    // [R12] threshold readback, zero in simple mode
    status_word[THR_LSB +: FIELD_W] = DESC_ENGINE_PRESENT ? thr_q : 8'h00;
    // [R13] delay readback, zero in simple mode
    status_word[WAIT_LSB +: FIELD_W] = DESC_ENGINE_PRESENT ? wait_q : 8'h00;
    rd_data = (rd_addr[ADDR_W-1:2] == STAT_OFS[ADDR_W-1:2]) ?
              status_word : ctrl_word;
  end

  // outputs from registers
  assign run_stop_control = run_q;
  assign irq_count_limit_cfg = thr_q;
  assign irq_wait_time_cfg = wait_q;
  assign irq = irq_q;

  // checks on the status behaviour
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_desc_fault;
    desc_err;
  endsequence

  sequence s_run_dropped;
    !run_stop_control ##1 !stopped_indication;
  endsequence

  // only a running engine must show the drain step; a software stop
  // already under way may legally finish right after the fault
  property p_graceful_halt;
    s_desc_fault ##0 run_stop_control ##0 !stopped_indication |=>
      s_run_dropped;
  endproperty

  // [R1] internal fault and tail marking
  a_internal_fault: assert property ( // [R1]
    int_ev |-> treat_as_tail ##1 status_word[INT_FAULT_BIT])
    else $error("internal fault not raised");

  // [R2] run clears before stopped rises
  a_graceful_halt: assert property (p_graceful_halt) // [R2]
    else $error("halt order broken");

  // [R2] stopped rises only after idle engine
  a_stop_after_idle: assert property ( // [R2]
    $rose(stopped_indication) |-> $past(engine_idle) && $past(!run_q))
    else $error("stopped before drain");

  // [R3] slave fault latches
  a_slave_fault: assert property ( // [R3]
    slv_ev |=> status_word[SLV_FAULT_BIT] [*2])
    else $error("slave fault not latched");

  // [R4] decode fault latches
  a_decode_fault: assert property ( // [R4]
    dec_ev |=> status_word[DEC_FAULT_BIT])
    else $error("decode fault not latched");

  // [R6] simple mode faults zero
  a_simple_faults: assert property ( // [R6]
    !DESC_ENGINE_PRESENT |-> status_word[DEC_FAULT_BIT:INT_FAULT_BIT] == 3'h0)
    else $error("fault visible in simple mode");

  // [R7] reserved bits zero
  a_reserved_zero: assert property ( // [R7]
    !status_word[RSV_LO_BIT] && !status_word[RSV_HI_BIT])
    else $error("reserved bit set");

  // [R8] completion flag set
  a_completion_set: assert property ( // [R8]
    cmp_ev |=> flag_q[0])
    else $error("completion flag missed");

  // [R9] completion irq gating
  a_completion_irq: assert property ( // [R9]
    flag_q[0] && !en_q[0] && !flag_q[1] && !flag_q[2] |=> !irq)
    else $error("irq without enable");

  // [R11] error flag drives irq while its enable holds
  a_error_irq: assert property ( // [R11]
    err_ev ##1 en_q[2] |=> irq)
    else $error("error irq missing");

  // [R12] threshold readback
  a_threshold_view: assert property ( // [R12]
    ctrl_wr && wr_strb[LANE_THR] && DESC_ENGINE_PRESENT |=>
      status_word[THR_LSB +: FIELD_W] == $past(wr_data[THR_LSB +: FIELD_W]))
    else $error("threshold readback wrong");

  // [R14] clear without event empties the flag
  a_w1c_clear: assert property ( // [R14]
    clr_vec[2] && !err_ev |=> !flag_q[2])
    else $error("flag not cleared");

endmodule : s2mm_dma_status_upper
`default_nettype wire

/* File: verif/s2mm_dma_status_upper_tb.sv */
// self-checking bench for the upper status block over axi4-lite
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
  n_mismatch++; $display("ERROR %s expected %h seen %h", nm, e, g); end end
module s2mm_dma_status_upper_tb;
  import dma_status_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [DATA_W-1:0] s_axi_wdata = '0, s_axi_rdata, sm_rdata;
  logic [STRB_W-1:0] s_axi_wstrb = '0;
  // response readies held high throughout, answers taken when seen
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b1;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, sm_awready, sm_wready, sm_bvalid, sm_arready;
  logic sm_rvalid, sm_run, sm_stop, sm_tail, sm_irq;
  logic [1:0] s_axi_bresp, s_axi_rresp, sm_bresp, sm_rresp;
  logic desc_fetch_done = 1'b0, desc_fetch_cmplt_set = 1'b0;
  logic desc_resp_valid = 1'b0, desc_resp_slverr = 1'b0;
  logic desc_resp_decerr = 1'b0, eof_desc_done = 1'b0, xfer_done = 1'b0;
  logic delay_timeout = 1'b0, datapath_error = 1'b0;
  logic threshold_reached = 1'b0, engine_idle = 1'b0;
  logic run_stop_control, stopped_indication, treat_as_tail, irq;
  logic [7:0] irq_count_limit_cfg, irq_wait_time_cfg, sm_thr, sm_wait;
  logic [31:0] rd_v, rd_s, exp_v;
  logic [1:0] resp;
  logic tail;
  int n_mismatch = 0;
  int n_checks = 0;
  int cyc = 0;

  // descriptor-engine build under test
  s2mm_dma_status_upper #(.DESC_ENGINE_PRESENT(1'b1)) dut_u (.*);

  // simple-mode build sharing every input
  s2mm_dma_status_upper #(.DESC_ENGINE_PRESENT(1'b0)) dut_simple_u (
    .s_axi_awready(sm_awready), .s_axi_wready(sm_wready),
    .s_axi_bresp(sm_bresp), .s_axi_bvalid(sm_bvalid),
    .s_axi_arready(sm_arready), .s_axi_rdata(sm_rdata),
    .s_axi_rresp(sm_rresp), .s_axi_rvalid(sm_rvalid),
    .run_stop_control(sm_run), .stopped_indication(sm_stop),
    .treat_as_tail(sm_tail), .irq_count_limit_cfg(sm_thr),
    .irq_wait_time_cfg(sm_wait), .irq(sm_irq), .*);

  // 20 mhz clock
  always #25 aclk = ~aclk;

  // hang guard
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    if (n_mismatch == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_of_test

  // one write: address and data offered together, wait for response
  task automatic wr(input logic [3:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        r = s_axi_bresp;
        break;
      end
    end
  endtask : wr

  // one read, capturing both builds
  task automatic rd(input logic [3:0] a, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        rd_v = s_axi_rdata;
        rd_s = sm_rdata;
        r = s_axi_rresp;
        break;
      end
    end
  endtask : rd

  task automatic chk_rd(input logic [3:0] a, input logic [31:0] e);
    rd(a, resp);
    `CHK("rdata", e, rd_v)
  endtask : chk_rd

  task automatic wr_ok(input logic [3:0] a, input logic [31:0] d);
    wr(a, d, resp);
    `CHK("bresp", RESP_OKAY, resp)
  endtask : wr_ok

  // one-cycle event pulse; tail sampled while the pulse is up
  task automatic pulse(input int k);
    @(posedge aclk);
    case (k)
      0: {desc_fetch_done, desc_fetch_cmplt_set} <= 2'b11;
      1: {desc_resp_valid, desc_resp_slverr} <= 2'b11;
      2: {desc_resp_valid, desc_resp_decerr} <= 2'b11;
      3: eof_desc_done <= 1'b1;
      4: delay_timeout <= 1'b1;
      5: datapath_error <= 1'b1;
      default: xfer_done <= 1'b1;
    endcase
    @(posedge aclk);
    tail = treat_as_tail;
    {desc_fetch_done, desc_fetch_cmplt_set, desc_resp_valid} <= '0;
    {desc_resp_slverr, desc_resp_decerr, eof_desc_done} <= '0;
    {delay_timeout, datapath_error, xfer_done} <= '0;
  endtask : pulse

  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    // reset values of both registers
    chk_rd(STAT_OFS, 32'h0001_0001);
    chk_rd(CTRL_OFS, 32'h0001_0000);
    // unmapped place answers with a decode error
    wr(4'h8, 32'hffff_ffff, resp);
    `CHK("bresp unmapped", RESP_DECERR, resp)
    rd(4'hc, resp);
    `CHK("rresp unmapped", RESP_DECERR, resp)
    `CHK("rdata unmapped", 32'h0000_0000, rd_v)
    // run, all enables, threshold 05h, delay a3h
    wr_ok(CTRL_OFS, 32'ha305_7001);
    chk_rd(STAT_OFS, 32'ha305_0000);
    // read-only and reserved bits ignore writes
    wr_ok(STAT_OFS, 32'hffff_ffff);
    chk_rd(STAT_OFS, 32'ha305_0000);
    // completion held back until the threshold is met
    pulse(3);
    repeat (3) @(posedge aclk);
    `CHK("irq below threshold", 1'b0, irq)
    chk_rd(STAT_OFS, 32'ha305_1000);
    threshold_reached <= 1'b1;
    repeat (3) @(posedge aclk);
    `CHK("irq completion", 1'b1, irq)
    wr_ok(STAT_OFS, 32'h0000_0000);
    chk_rd(STAT_OFS, 32'ha305_1000);
    wr_ok(STAT_OFS, 32'h0000_1000);
    repeat (3) @(posedge aclk);
    `CHK("irq after clear", 1'b0, irq)
    // delay timeout
    pulse(4);
    repeat (3) @(posedge aclk);
    `CHK("irq delay", 1'b1, irq)
    chk_rd(STAT_OFS, 32'ha305_2000);
    wr_ok(STAT_OFS, 32'h0000_2000);
    // error flag with its enable masked, then unmasked
    wr_ok(CTRL_OFS, 32'ha305_3001);
    pulse(5);
    repeat (3) @(posedge aclk);
    `CHK("irq error masked", 1'b0, irq)
    chk_rd(STAT_OFS, 32'ha305_4000);
    wr_ok(CTRL_OFS, 32'ha305_7001);
    repeat (3) @(posedge aclk);
    `CHK("irq error", 1'b1, irq)
    wr_ok(STAT_OFS, 32'h0000_4000);
    repeat (3) @(posedge aclk);
    `CHK("irq error cleared", 1'b0, irq)
    // each descriptor fault: run drops first, stopped after drain
    exp_v = 32'ha305_4001;
    for (int k = 0; k < 3; k++) begin
      engine_idle <= 1'b0;
      wr_ok(CTRL_OFS, 32'ha305_7001);
      pulse(k);
      `CHK("tail marker", (k == 0), tail)
      @(posedge aclk);
      `CHK("run cleared", 1'b0, run_stop_control)
      repeat (4) @(posedge aclk);
      `CHK("stopped early", 1'b0, stopped_indication)
      engine_idle <= 1'b1;
      repeat (3) @(posedge aclk);
      `CHK("stopped", 1'b1, stopped_indication)
      exp_v[8 + k] = 1'b1;
      chk_rd(STAT_OFS, exp_v);
      wr_ok(STAT_OFS, 32'h0000_4700);
    end
    // faults stay set after a clearing write
    chk_rd(STAT_OFS, 32'ha305_0701);
    `CHK("simple mode unused bits", 32'h0, rd_s & 32'hffff_2700)
    // simple-mode completion source; the engine build ignores it
    pulse(6);
    repeat (3) @(posedge aclk);
    `CHK("simple irq completion", 1'b1, sm_irq)
    `CHK("irq transfer done", 1'b0, irq)
    // completion flag raised with its enable off
    wr_ok(CTRL_OFS, 32'ha305_6000);
    pulse(3);
    repeat (3) @(posedge aclk);
    `CHK("irq completion masked", 1'b0, irq)
    `CHK("simple irq masked", 1'b0, sm_irq)
    chk_rd(STAT_OFS, 32'ha305_1701);
    `CHK("simple status", 32'h0000_1001, rd_s)
    `CHK("threshold out", 8'h05, irq_count_limit_cfg)
    `CHK("delay out", 8'ha3, irq_wait_time_cfg)
    end_of_test();
  end
endmodule : s2mm_dma_status_upper_tb
`default_nettype wire
